// *** hw/ttp_pkg.sv ***
// package: register map, field layout and constants of the type 3 panel block
package ttp_pkg;
  localparam logic [7:0] TTP_OFS_CLKDIV = 8'hE0;
  localparam logic [7:0] TTP_OFS_PCTRL = 8'hE4;
  localparam logic [7:0] TTP_OFS_AREA0 = 8'hE8;
  localparam logic [7:0] TTP_OFS_AREA1 = 8'hEC;
  localparam logic [7:0] TTP_OFS_AREA2 = 8'hF0;
  localparam logic [7:0] TTP_OFS_CMD = 8'hF4;
  localparam logic [7:0] TTP_OFS_MISC = 8'hF8;
  localparam logic [31:0] TTP_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] TTP_MASK_CLKDIV = 32'h0000_003F;
  localparam logic [31:0] TTP_MASK_PCTRL = 32'h0000_3F1F;
  localparam logic [31:0] TTP_MASK_AREA = 32'h3F3F_3F3F;
  localparam logic [31:0] TTP_MASK_CMD = 32'h0FFF_0FFF;
  localparam logic [31:0] TTP_MASK_MISC = 32'h0000_0301;
  localparam int TTP_NAREA = 3;
  localparam int TTP_BIT_PEN = 4;
  localparam int TTP_BIT_BLOCK = 3;
  localparam int TTP_BIT_REQ = 0;
  localparam int TTP_POS_W = 6;
  localparam int TTP_UNIT_SH = 3;
  localparam int TTP_CNT_W = 9;
  localparam logic [4:0] TTP_DIV2_BASE = 5'h06;
  localparam logic [4:0] TTP_DIV_ONE = 5'h01;
  localparam logic [16:0] TTP_ONE17 = 17'h0_0001;
  localparam int TTP_CMD_W = 12;
  localparam int TTP_SHIFT_LEN = 24;
  localparam int TTP_AREA_STEP = 4;
  localparam int TTP_LSB_DIV1 = 0;
  localparam int TTP_W_DIV1 = 4;
  localparam int TTP_LSB_DIV2 = 4;
  localparam int TTP_W_DIV2 = 2;
  localparam int TTP_LSB_XSTART = 0;
  localparam int TTP_LSB_YSTART = 8;
  localparam int TTP_LSB_XEND = 16;
  localparam int TTP_LSB_YEND = 24;
  localparam int TTP_LSB_REFRESH = 8;
  localparam int TTP_LSB_DRV = 8;
  localparam int TTP_DRV_W = 2;
  localparam int TTP_LSB_CMD0 = 0;
  localparam int TTP_LSB_CMD1 = 16;
endpackage : ttp_pkg

// *** hw/ttp_div_if.sv ***
// interface: enable and half period handed to the panel clock divider
interface ttp_div_if;
  logic enable;
  logic [16:0] halfPeriod;
  logic tick;
  modport ctrl (output enable, output halfPeriod, input tick);
  modport div (input enable, input halfPeriod, output tick);
endinterface : ttp_div_if

// *** hw/ttp_clk_div.sv ***
// module: programmable panel clock divider
module ttp_clk_div (
  input wire logic clock,
  input wire logic resetn,
  ttp_div_if.div cfg,
  output logic clockOut
);
  import ttp_pkg::*;
  logic [16:0] count;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      clockOut <= 1'b0;
    end else if (!cfg.enable) begin
      count <= '0;
      clockOut <= 1'b0;
    end else if (count + TTP_ONE17 >= cfg.halfPeriod) begin
      count <= '0;
      clockOut <= ~clockOut;
    end else begin
      count <= count + TTP_ONE17;
    end
  end

  assign cfg.tick = cfg.enable && !clockOut &&
    (count + TTP_ONE17 >= cfg.halfPeriod);
endmodule : ttp_clk_div

// *** hw/ttp_panel_ctrl.sv ***
// module: type 3 panel partial mode, command store and clock control

module ttp_panel_ctrl (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic type3Select,
  input wire logic displayActive,
  input wire logic [9:0] pixelX,
  input wire logic [9:0] lineY,
  output logic panelClockOne,
  output logic panelClockTwo,
  output logic partialShow,
  output logic [5:0] refreshCycle,
  output logic [1:0] columnDriverCount,
  output logic cmdClock,
  output logic cmdData,
  output logic cmdActive
);
  import ttp_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TTP_IDLE = 3'b001,
    TTP_WAIT = 3'b010,
    TTP_SEND = 3'b100
  } ttp_state_e;

  logic [31:0] clkDiv;
  logic [31:0] partialCtrl;
  logic [31:0] areaWin [TTP_NAREA];
  logic [31:0] cmdStore;
  logic [31:0] miscCtrl;
  logic cmdDone;
  ttp_state_e state;
  ttp_state_e next_state;
  logic [TTP_SHIFT_LEN-1:0] shiftReg;
  logic [4:0] bitCount;
  logic [2:0] dispSync;
  logic dispLevel;
  logic blankTime;
  logic sendStart;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [5:0] pos6(input logic [31:0] w, input int lsb);
    pos6 = w[lsb +: TTP_POS_W];
  endfunction : pos6

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clkDiv <= TTP_RST_ZERO;
    end else if (regWrite && hit(regAddr, TTP_OFS_CLKDIV)) begin
      clkDiv <= regWdata & TTP_MASK_CLKDIV;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      partialCtrl <= TTP_RST_ZERO;
    end else if (regWrite && hit(regAddr, TTP_OFS_PCTRL)) begin
      partialCtrl <= regWdata & TTP_MASK_PCTRL;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TTP_NAREA; g++) begin : gArea
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          areaWin[g] <= TTP_RST_ZERO;
        end else if (regWrite &&
                     hit(regAddr, TTP_OFS_AREA0 + 8'(TTP_AREA_STEP * g))) begin
          areaWin[g] <= regWdata & TTP_MASK_AREA;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmdStore <= TTP_RST_ZERO;
    end else if (regWrite && hit(regAddr, TTP_OFS_CMD)) begin
      cmdStore <= regWdata & TTP_MASK_CMD;
    end
  end

  // request bit: hardware clear loses to a new software set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      miscCtrl <= TTP_RST_ZERO;
    end else if (regWrite && hit(regAddr, TTP_OFS_MISC)) begin
      miscCtrl <= regWdata & TTP_MASK_MISC;
    end else if (cmdDone) begin
      miscCtrl[TTP_BIT_REQ] <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata <= TTP_RST_ZERO;
    end else if (regRead) begin
      unique case (regAddr)
        TTP_OFS_CLKDIV: regRdata <= clkDiv;
        TTP_OFS_PCTRL: regRdata <= partialCtrl;
        TTP_OFS_AREA0: regRdata <= areaWin[0];
        TTP_OFS_AREA1: regRdata <= areaWin[1];
        TTP_OFS_AREA2: regRdata <= areaWin[2];
        TTP_OFS_CMD: regRdata <= cmdStore;
        TTP_OFS_MISC: regRdata <= miscCtrl;
        default: regRdata <= TTP_RST_ZERO;
      endcase
    end else begin
      regRdata <= TTP_RST_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // panel clock dividers
  // ---------------------------------------------------------------
  ttp_div_if divOne ();
  ttp_div_if divTwo ();
  logic [4:0] expOne;
  logic [4:0] expTwo;

  assign expOne = 5'(clkDiv[TTP_LSB_DIV1 +: TTP_W_DIV1]);
  assign expTwo = TTP_DIV2_BASE +
    5'(clkDiv[TTP_LSB_DIV2 +: TTP_W_DIV2]);
  assign divOne.enable = type3Select;
  assign divTwo.enable = type3Select;
  // half period is the divide factor over two
  assign divOne.halfPeriod = TTP_ONE17 << expOne;
  assign divTwo.halfPeriod = TTP_ONE17 << (expTwo - TTP_DIV_ONE);

  ttp_clk_div uDivOne (
    .clock(clock),
    .resetn(resetn),
    .cfg(divOne.div),
    .clockOut(panelClockOne)
  );

  ttp_clk_div uDivTwo (
    .clock(clock),
    .resetn(resetn),
    .cfg(divTwo.div),
    .clockOut(panelClockTwo)
  );

  // ---------------------------------------------------------------
  // partial mode area decode
  // ---------------------------------------------------------------
  function automatic logic inSpan(input logic [9:0] pos,
                                  input logic [5:0] first,
                                  input logic [5:0] last);
    logic [5:0] unit;
    unit = pos[TTP_UNIT_SH +: TTP_POS_W];
    inSpan = (unit >= first) && (unit <= last);
  endfunction : inSpan

  logic [TTP_NAREA-1:0] areaHit;
  logic [9:0] xPipe;
  logic [9:0] yPipe;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      xPipe <= '0;
    end else begin
      xPipe <= pixelX;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      yPipe <= '0;
    end else begin
      yPipe <= lineY;
    end
  end

  generate
    for (g = 0; g < TTP_NAREA; g++) begin : gHit
      logic yIn;
      logic xIn;
      assign yIn = inSpan(yPipe, pos6(areaWin[g], TTP_LSB_YSTART),
                          pos6(areaWin[g], TTP_LSB_YEND));
      assign xIn = inSpan(xPipe, pos6(areaWin[g], TTP_LSB_XSTART),
                          pos6(areaWin[g], TTP_LSB_XEND));
      assign areaHit[g] = partialCtrl[g] && yIn &&
        (!partialCtrl[TTP_BIT_BLOCK] || xIn);
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      partialShow <= 1'b0;
    end else begin
      partialShow <= type3Select && (!partialCtrl[TTP_BIT_PEN] ||
                                     (|areaHit));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refreshCycle <= '0;
    end else if (type3Select) begin
      refreshCycle <= pos6(partialCtrl, TTP_LSB_REFRESH);
    end else begin
      refreshCycle <= '0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      columnDriverCount <= '0;
    end else if (type3Select) begin
      columnDriverCount <= miscCtrl[TTP_LSB_DRV +: TTP_DRV_W];
    end else begin
      columnDriverCount <= '0;
    end
  end

  // ---------------------------------------------------------------
  // command send
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dispSync <= '0;
    end else begin
      dispSync <= {dispSync[1:0], displayActive};
    end
  end

  // display level moves once second and third stages agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dispLevel <= 1'b0;
    end else if (dispSync[1] == dispSync[2]) begin
      dispLevel <= dispSync[2];
    end
  end

  assign blankTime = !dispLevel;
  assign sendStart = (state == TTP_WAIT) && blankTime && type3Select;

  always_comb begin
    next_state = state;
    unique case (state)
      TTP_IDLE: begin
        if (miscCtrl[TTP_BIT_REQ] && type3Select) begin
          next_state = TTP_WAIT;
        end
      end
      TTP_WAIT: begin
        if (sendStart) begin
          next_state = TTP_SEND;
        end
      end
      TTP_SEND: begin
        if (bitCount == 5'(TTP_SHIFT_LEN - 1)) begin
          next_state = TTP_IDLE;
        end
      end
      default: next_state = TTP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= TTP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shiftReg <= '0;
    end else if (sendStart) begin
      shiftReg <= {cmdStore[TTP_LSB_CMD1 +: TTP_CMD_W],
                   cmdStore[TTP_LSB_CMD0 +: TTP_CMD_W]};
    end else if (state == TTP_SEND) begin
      shiftReg <= {shiftReg[TTP_SHIFT_LEN-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bitCount <= '0;
    end else if (sendStart) begin
      bitCount <= '0;
    end else if (state == TTP_SEND) begin
      bitCount <= bitCount + 5'h01;
    end
  end

  assign cmdDone = (state == TTP_SEND) &&
    (bitCount == 5'(TTP_SHIFT_LEN - 1));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmdData <= 1'b0;
    end else begin
      cmdData <= (state == TTP_SEND) ? shiftReg[TTP_SHIFT_LEN-1] : 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmdActive <= 1'b0;
    end else begin
      cmdActive <= (state == TTP_SEND);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmdClock <= 1'b0;
    end else begin
      cmdClock <= (state == TTP_SEND) && !cmdClock;
    end
  end
endmodule : ttp_panel_ctrl

// *** test/ttp_panel_ctrl_props.sv ***
// checker: port-level properties of the type 3 panel block
module ttp_panel_ctrl_props (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic type3Select,
  input wire logic displayActive,
  input wire logic panelClockOne,
  input wire logic panelClockTwo,
  input wire logic [5:0] refreshCycle,
  input wire logic [1:0] columnDriverCount,
  input wire logic cmdActive
);
  timeunit 1ns;
  timeprecision 100ps;
  import ttp_pkg::*;
  logic [4:0] actCnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----
  // length of the send phase
  // ----
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) actCnt <= 5'h00;
    else actCnt <= cmdActive ? actCnt + 5'h01 : 5'h00;
  end
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  gate_off_a: assert property (!type3Select |=>
    refreshCycle == 6'h00 && columnDriverCount == 2'h0)
    else $error("settings leak without type 3");
  clk_gate_a: assert property (!type3Select [*3] |->
    !panelClockOne && !panelClockTwo) else $error("panel clock runs");
  refresh_copy_a: assert property (
    regRead && regAddr == TTP_OFS_PCTRL && type3Select
    |=> refreshCycle == regRdata[13:8]) else $error("refresh copy wrong");
  drv_copy_a: assert property (
    regRead && regAddr == TTP_OFS_MISC && type3Select
    |=> columnDriverCount == regRdata[9:8]) else $error("driver count wrong");
  cmd_len_a: assert property ($fell(cmdActive) |-> actCnt == 5'h18)
    else $error("send phase length wrong");
  cmd_max_a: assert property (actCnt <= 5'h18)
    else $error("send phase too long");
  cmd_blank_a: assert property ($rose(cmdActive) |->
    $past(type3Select, 2) && !$past(displayActive, 5) &&
    !$past(displayActive, 6))
    else $error("send outside blanking");
  cover property ($rose(cmdActive));
  cover property ($rose(panelClockTwo));
  cover property (regRead && regAddr == TTP_OFS_PCTRL);
endmodule : ttp_panel_ctrl_props

bind ttp_panel_ctrl ttp_panel_ctrl_props u_props (.clock(clock),
  .resetn(resetn), .regAddr(regAddr), .regRead(regRead),
  .regRdata(regRdata), .type3Select(type3Select),
  .displayActive(displayActive), .panelClockOne(panelClockOne),
  .panelClockTwo(panelClockTwo), .refreshCycle(refreshCycle),
  .columnDriverCount(columnDriverCount), .cmdActive(cmdActive));

// *** test/ttp_panel_model.sv ***
// partner: column driver taking the serial command word
module ttp_panel_model (
  input wire logic clock,
  input wire logic cmdData,
  input wire logic cmdActive,
  input wire logic cmdClock,
  output logic [23:0] got,
  output logic [4:0] nBits,
  output logic [4:0] nClk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    got = 24'h0;
    nBits = 5'h00;
    nClk = 5'h00;
  end
  // one bit per clock while the send phase lasts, first bit highest
  always @(posedge clock) begin
    if (cmdActive) begin
      got <= {got[22:0], cmdData};
      nBits <= nBits + 5'h01;
      if (cmdClock) nClk <= nClk + 5'h01;
    end
  end
endmodule : ttp_panel_model

// *** test/test_type3_tft_partial_cmd_ctrl.sv ***
// testbench: register, divider, partial area and command checks
module test_type3_tft_partial_cmd_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import ttp_pkg::*;
  logic clock, resetn, regWrite, regRead, type3Select, displayActive;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rv;
  logic [9:0] pixelX, lineY;
  logic panelClockOne, panelClockTwo, partialShow, cmdClock, cmdData;
  logic cmdActive;
  logic [5:0] refreshCycle;
  logic [1:0] columnDriverCount;
  logic [23:0] got;
  logic [4:0] nBits, nClk;
  int nFail, checks, i;
  localparam logic [39:0] ROWS [8] = '{
    {8'hE0, 32'h3E}, {8'hE4, 32'h3F1E}, {8'hE8, 32'h3F3F_3F3E},
    {8'hEC, 32'h3F3F_3F3E}, {8'hF0, 32'h3F3F_3F3E}, {8'hF4, 32'h0FFF_0FFE},
    {8'hF8, 32'h300}, {8'hD0, 32'h0}};
  localparam logic [7:0] PC [6] = '{8'h19, 8'h19, 8'h11, 8'h11, 8'h01, 8'h1C};
  localparam logic [9:0] PX [6] = '{10'h14, 10'h28, 10'h28, 10'h28, 10'h28,
    10'h14};
  localparam logic [9:0] PY [6] = '{10'h28, 10'h28, 10'h28, 10'h08, 10'h08,
    10'h28};
  localparam logic PE [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  ttp_panel_ctrl u_dut (.clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .type3Select(type3Select),
    .displayActive(displayActive), .pixelX(pixelX), .lineY(lineY),
    .panelClockOne(panelClockOne), .panelClockTwo(panelClockTwo),
    .partialShow(partialShow), .refreshCycle(refreshCycle),
    .columnDriverCount(columnDriverCount), .cmdClock(cmdClock),
    .cmdData(cmdData), .cmdActive(cmdActive));
  ttp_panel_model u_model (.clock(clock), .cmdData(cmdData),
    .cmdActive(cmdActive), .cmdClock(cmdClock), .got(got), .nBits(nBits),
    .nClk(nClk));

  // ----
  // tasks
  // ----
  task print_verdict;
    if (nFail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      nFail++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask : rd
  task per(input bit s, input logic [31:0] e);
    int n, k, t0;
    logic p, c;
    k = 0;
    t0 = 0;
    p = 1'b1;
    for (n = 0; n < 1600 && k < 3; n++) begin
      @(negedge clock);
      c = s ? panelClockTwo : panelClockOne;
      if (c && !p) k++;
      if (c && !p && k == 2) t0 = n;
      if (c && !p && k == 3) chk(n - t0, e);
      p = c;
    end
    if (k < 3) nFail++;
    if (k < 3) print_verdict;
  endtask : per

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #400us;
    nFail++;
    print_verdict;
  end
  // ----
  // sequence
  // ----
  initial begin
    {resetn, regWrite, regRead, displayActive} = 4'h0;
    type3Select = 1'b1;
    regAddr = 8'h0;
    regWdata = 32'h0;
    {pixelX, lineY} = 20'h0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(ROWS[i][39:32], rv);
      chk(rv, 32'h0);
      wr(ROWS[i][39:32], 32'hFFFF_FFFE);
      rd(ROWS[i][39:32], rv);
      chk(rv, ROWS[i][31:0]);
    end
    chk({26'h0, refreshCycle}, 32'h3F);
    chk({30'h0, columnDriverCount}, 32'h3);
    for (i = 0; i < 4; i++) begin
      wr(TTP_OFS_CLKDIV, 32'(i) << 4);
      per(1'b1, 32'h40 << i);
    end
    for (i = 0; i < 9; i++) begin
      wr(TTP_OFS_CLKDIV, 32'(i));
      per(1'b0, 32'h2 << i);
    end
    wr(TTP_OFS_AREA0, 32'h0503_0402);
    for (i = 0; i < 6; i++) begin
      wr(TTP_OFS_PCTRL, {24'h0, PC[i]});
      pixelX <= PX[i];
      lineY <= PY[i];
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk({31'h0, partialShow}, {31'h0, PE[i]});
    end
    wr(TTP_OFS_CMD, 32'h0A5C_0123);
    type3Select <= 1'b0;
    wr(TTP_OFS_MISC, 32'h301);
    repeat (40) @(posedge clock);
    chk({26'h0, refreshCycle}, 32'h0);
    chk({30'h0, columnDriverCount}, 32'h0);
    chk({31'h0, partialShow}, 32'h0);
    rd(TTP_OFS_MISC, rv);
    chk(rv, 32'h301);
    displayActive <= 1'b1;
    repeat (5) @(posedge clock);
    type3Select <= 1'b1;
    repeat (20) @(posedge clock);
    chk({27'h0, nBits}, 32'h0);
    displayActive <= 1'b0;
    for (i = 0; i < 100 && nBits != 5'h18; i++) @(posedge clock);
    repeat (4) @(posedge clock);
    chk({8'h0, got}, 32'h00A5_C123);
    chk({27'h0, nBits}, 32'h18);
    chk({27'h0, nClk}, 32'h0C);
    rd(TTP_OFS_MISC, rv);
    chk(rv, 32'h300);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(TTP_OFS_PCTRL, rv);
    chk(rv, 32'h0);
    print_verdict;
  end
endmodule : test_type3_tft_partial_cmd_ctrl
